// ==== hw/asr_regs.svh ====
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ASR_ADDR_W 18
`define ASR_DEPTH 262144
// ----------------------------------------------------------------
// Timing in ns, slowest grade, and derived cycle counts at 10 ns
// ----------------------------------------------------------------
`define ASR_CLK_NS 10
`define ASR_ADDR_TO_OUT_VALID_NS 35
`define ASR_SELECT_TO_OUT_VALID_NS 35
`define ASR_DESELECT_TO_OUT_FLOAT_NS 15
`define ASR_SELECT_TO_WRITE_END_NS 25
`define ASR_STROBE_LOW_TO_WRITE_END_NS 20
`define ASR_ADDR_SETUP_WRITE_END_NS 25
`define ASR_DATA_SETUP_WRITE_END_NS 15
// Least times round up; sample waits add two for the pin synchroniser
`define ASR_CEIL(t) (((t) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_RD_CYC (`ASR_CEIL(`ASR_ADDR_TO_OUT_VALID_NS) + 2)
`define ASR_WR_CYC `ASR_CEIL(`ASR_SELECT_TO_WRITE_END_NS)
`define ASR_FLOAT_CYC `ASR_CEIL(`ASR_DESELECT_TO_OUT_FLOAT_NS)
`endif

// ==== hw/asr_pkg.sv ====
package asr_pkg;
    typedef enum logic [4:0] {
        ASR_IDLE  = 5'h01,
        ASR_SETUP = 5'h02,
        ASR_READ  = 5'h04,
        ASR_WRITE = 5'h08,
        ASR_GAP   = 5'h10
    } asr_state_type;
endpackage

// ==== hw/asr_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module asr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ==== hw/asr_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "asr_regs.svh"
module asr_host (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire logic                   req_write,
    input  wire logic [`ASR_ADDR_W-1:0] req_addr,
    input  wire logic                   req_wdata,
    output logic                        rsp_valid,
    output logic                        rsp_rdata,
    output logic [`ASR_ADDR_W-1:0]      mem_addr,
    output logic                        mem_din,
    output logic                        mem_select_n,
    output logic                        mem_strobe_n,
    input  wire logic                   mem_dout,
    input  wire logic                   mem_dout_oe
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        asr_pkg::asr_state_type st;
        logic [7:0]             cnt;
        logic                   wr;
        logic [`ASR_ADDR_W-1:0] addr;
        logic                   din;
        logic                   sel_n;
        logic                   stb_n;
        logic                   rsp_v;
        logic                   rdata;
    } asr_host_state_type;

    localparam logic [7:0] RD_CYC    = 8'(`ASR_RD_CYC);
    localparam logic [7:0] WR_CYC    = 8'(`ASR_WR_CYC);
    localparam logic [7:0] FLOAT_CYC = 8'(`ASR_FLOAT_CYC);

    asr_host_state_type cur_ff;
    asr_host_state_type nxt_s;
    logic               dout_s;
    logic               oe_s;

    // Pins from the memory are asynchronous
    asr_sync u_sync_dout (
        .clk  (clk),
        .rst  (rst),
        .din  (mem_dout),
        .dout (dout_s)
    );
    asr_sync u_sync_oe (
        .clk  (clk),
        .rst  (rst),
        .din  (mem_dout_oe),
        .dout (oe_s)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = cur_ff;
        nxt_s.rsp_v = 1'b0;
        case (cur_ff.st)
            asr_pkg::ASR_IDLE: begin
                if (req_valid) begin
                    // Address and data move only while both controls high
                    nxt_s.addr = req_addr;
                    nxt_s.din  = req_wdata;
                    nxt_s.wr   = req_write;
                    nxt_s.st   = asr_pkg::ASR_SETUP;
                end
            end
            asr_pkg::ASR_SETUP: begin
                // Strobe falls with select, so write starts on both low
                nxt_s.sel_n = 1'b0;
                nxt_s.stb_n = ~cur_ff.wr;
                nxt_s.cnt   = cur_ff.wr ? WR_CYC : RD_CYC;
                nxt_s.st    = cur_ff.wr ? asr_pkg::ASR_WRITE
                                        : asr_pkg::ASR_READ;
            end
            asr_pkg::ASR_READ: begin
                if (cur_ff.cnt > 8'h01) begin
                    nxt_s.cnt = cur_ff.cnt - 8'h01;
                end else begin
                    // Sample before deselect; data only trusted if driven
                    nxt_s.rdata = dout_s & oe_s;
                    nxt_s.rsp_v = 1'b1;
                    nxt_s.sel_n = 1'b1;
                    nxt_s.cnt   = FLOAT_CYC;
                    nxt_s.st    = asr_pkg::ASR_GAP;
                end
            end
            asr_pkg::ASR_WRITE: begin
                if (cur_ff.cnt > 8'h01) begin
                    nxt_s.cnt = cur_ff.cnt - 8'h01;
                end else begin
                    // Both rise together; addr and data held past it
                    nxt_s.sel_n = 1'b1;
                    nxt_s.stb_n = 1'b1;
                    nxt_s.rsp_v = 1'b1;
                    nxt_s.cnt   = FLOAT_CYC;
                    nxt_s.st    = asr_pkg::ASR_GAP;
                end
            end
            asr_pkg::ASR_GAP: begin
                // Lets a read output float before the next cycle
                if (cur_ff.cnt > 8'h01) begin
                    nxt_s.cnt = cur_ff.cnt - 8'h01;
                end else begin
                    nxt_s.st = asr_pkg::ASR_IDLE;
                end
            end
            default: begin
                nxt_s.st    = asr_pkg::ASR_IDLE;
                nxt_s.sel_n = 1'b1;
                nxt_s.stb_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '{st: asr_pkg::ASR_IDLE, cnt: 8'h00, wr: 1'b0,
                        addr: '0, din: 1'b0, sel_n: 1'b1, stb_n: 1'b1,
                        rsp_v: 1'b0, rdata: 1'b0};
        end else begin
            cur_ff <= nxt_s;
        end
    end

    assign req_ready    = (cur_ff.st == asr_pkg::ASR_IDLE);
    assign rsp_valid    = cur_ff.rsp_v;
    assign rsp_rdata    = cur_ff.rdata;
    assign mem_addr     = cur_ff.addr;
    assign mem_din      = cur_ff.din;
    assign mem_select_n = cur_ff.sel_n;
    assign mem_strobe_n = cur_ff.stb_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence wr_start_s;
        $fell(mem_strobe_n);
    endsequence
    sequence wr_hold_s;
        (!mem_strobe_n && !mem_select_n)[*2];
    endsequence

    addr_stable_a: assert property (@(posedge clk) disable iff (rst)
        !$stable(mem_addr) |-> mem_select_n && mem_strobe_n)
        else $error("address moved while selected");
    read_strobe_a: assert property (@(posedge clk) disable iff (rst)
        cur_ff.st == asr_pkg::ASR_READ |-> mem_strobe_n)
        else $error("strobe low in read");
    write_width_a: assert property (@(posedge clk) disable iff (rst)
        wr_start_s |-> mem_select_n == 1'b0 ##0 wr_hold_s ##1
        (!mem_strobe_n)[*1])
        else $error("write too short");
    write_hold_a: assert property (@(posedge clk) disable iff (rst)
        $rose(mem_strobe_n) |-> $stable(mem_addr) && $stable(mem_din))
        else $error("addr or data moved at write end");
    write_end_a: assert property (@(posedge clk) disable iff (rst)
        $rose(mem_strobe_n) |-> $rose(mem_select_n))
        else $error("controls did not end together");
    read_wait_a: assert property (@(posedge clk) disable iff (rst)
        $fell(mem_select_n) && mem_strobe_n |->
        !mem_select_n [*4] ##1 !mem_select_n)
        else $error("read too short");
    float_gap_a: assert property (@(posedge clk) disable iff (rst)
        $rose(mem_select_n) |-> req_ready == 1'b0 ##1 !req_ready)
        else $error("no gap after deselect");
    rsp_once_a: assert property (@(posedge clk) disable iff (rst)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");

    // ----------------------------------------------------------------
    // Write window checks and response check
    // ----------------------------------------------------------------
    // Address and data are loaded a cycle ahead of select falling
    sequence ctl_fall_s;
        $fell(mem_select_n);
    endsequence

    addr_setup_a: assert property (@(posedge clk) disable iff (rst)
        ctl_fall_s |=> $stable(mem_addr) && $stable(mem_din))
        else $error("address or data moved after select fell");

    data_steady_a: assert property (@(posedge clk) disable iff (rst)
        !mem_select_n && !mem_strobe_n |-> $stable(mem_din))
        else $error("data moved during write");

    strobe_inside_a: assert property (@(posedge clk) disable iff (rst)
        !mem_strobe_n |-> !mem_select_n)
        else $error("strobe low without select");

    busy_rsp_a: assert property (@(posedge clk) disable iff (rst)
        rsp_valid |-> !req_ready)
        else $error("request taken while responding");
endmodule
`default_nettype wire

// ==== sim/asr_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "asr_regs.svh"
module asr_mem_model (
    input  wire logic [`ASR_ADDR_W-1:0] addr,
    input  wire logic                   din,
    input  wire logic                   select_n,
    input  wire logic                   strobe_n,
    output logic                        dout,
    output logic                        dout_oe
);
    logic                   mem [`ASR_DEPTH];
    logic [`ASR_ADDR_W-1:0] wa;
    logic                   wd;
    logic                   wr_on = 1'b0;
    logic                   awake = 1'b0;
    realtime                t_chg = 0.0;
    realtime                t_sel = 0.0;
    wire                    drive = !select_n && strobe_n;
    // -----------------------------------------------------------
    // Write on overlap, stored when either control rises
    // -----------------------------------------------------------
    always @(select_n or strobe_n) begin
        if (wr_on && (select_n || strobe_n)) mem[wa] = wd;
        if (!wr_on && !select_n && !strobe_n) begin
            wa = addr;
            wd = din;
        end
        wr_on = !select_n && !strobe_n;
    end
    always @(negedge select_n or negedge strobe_n or addr or drive)
        t_chg = $realtime;
    always @(drive)
        t_sel = $realtime;
    // Undriven or unsettled output toggles so stale data never matches
    always #1 begin
        awake = ($realtime - t_chg) < 35.0;
        dout_oe = drive && ($realtime - t_sel >= 3.0);
        dout = (drive && !awake) ? mem[addr] : ~dout;
    end
    initial dout = 1'b0;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "asr_regs.svh"
module tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   req_valid = 1'b0;
    logic                   req_write = 1'b0;
    logic                   req_wdata = 1'b0;
    logic [`ASR_ADDR_W-1:0] req_addr = '0;
    logic [`ASR_ADDR_W-1:0] mem_addr;
    logic                   req_ready, rsp_valid, rsp_rdata, mem_din;
    logic                   mem_select_n, mem_strobe_n, mem_dout, mem_dout_oe;
    int                     fail_count = 0;
    int                     total_checks = 0;
    int                     cyc = 0;
    always #5 clk = ~clk;
    asr_host i_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_addr(mem_addr), .mem_din(mem_din), .mem_select_n(mem_select_n),
        .mem_strobe_n(mem_strobe_n), .mem_dout(mem_dout),
        .mem_dout_oe(mem_dout_oe));
    asr_mem_model i_mem (.addr(mem_addr), .din(mem_din),
        .select_n(mem_select_n), .strobe_n(mem_strobe_n),
        .dout(mem_dout), .dout_oe(mem_dout_oe));
    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Request stays up with other values while busy: must be ignored
    task automatic xfer(input logic w, input logic [`ASR_ADDR_W-1:0] a,
                        input logic d);
        int n;
        int lw;
        n = 0;
        lw = 0;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_addr = ~a;
        req_write = ~w;
        while (rsp_valid !== 1'b1 && n < 20) begin
            check(mem_addr === a, "address moved");
            if (!w) check(mem_strobe_n === 1'b1, "strobe low in read");
            if (w) check(mem_din === d, "write data moved");
            if (mem_select_n === 1'b0 && mem_strobe_n === 1'b0) lw++;
            @(posedge clk);
            #1;
            n++;
        end
        req_valid = 1'b0;
        check(n == (w ? 4 : 7), "latency");
        if (w) check(lw >= `ASR_WR_CYC, "write pulse");
        else check(lw == 0 && rsp_rdata === d, "read data");
        check(mem_select_n && mem_strobe_n, "controls left low");
        n = 0;
        while (req_ready !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n == 2, "gap before ready");
    endtask
    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        #1;
        check(mem_select_n && mem_strobe_n && req_ready, "reset state");
        rst = 1'b0;
        xfer(1'b1, 18'h00000, 1'b1);
        xfer(1'b1, 18'h3ffff, 1'b0);
        xfer(1'b1, 18'h155aa, 1'b1);
        xfer(1'b0, 18'h00000, 1'b1);
        xfer(1'b0, 18'h3ffff, 1'b0);
        xfer(1'b0, 18'h155aa, 1'b1);
        xfer(1'b1, 18'h00000, 1'b0);
        xfer(1'b0, 18'h00000, 1'b0);
        test_done();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            test_done();
        end
    end
endmodule
`default_nettype wire
